// File: pmfs_store.sv
package pmfs_pkg;
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int CNT_W = 24;
    localparam int DIV_W = 48;
    localparam int DIV_STEPS = 48;

    localparam logic [5:0] OFS_IN1 = 6'h00;
    localparam logic [5:0] OFS_IN2 = 6'h04;
    localparam logic [5:0] OFS_IN3 = 6'h08;
    localparam logic [5:0] OFS_OUT1 = 6'h0c;
    localparam logic [5:0] OFS_OUT2 = 6'h10;
    localparam logic [5:0] OFS_OUT3 = 6'h14;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h1c;

    localparam int CW1_SEL_LSB = 0;
    localparam int CW1_AUTO_BIT = 4;
    localparam int CW1_LOAD_K_BIT = 5;
    localparam int CW1_LOAD_M_BIT = 6;
    localparam int CW1_CLR_OVS_BIT = 7;
    localparam int CW1_CLR_CNT_BIT = 8;
    localparam int CW1_LOAD_CH_LSB = 12;
    localparam int CW2_VIEW_LSB = 0;
    localparam int IN3_VALID_LSB = 0;
    localparam int IN3_OVS_LSB = 4;
    localparam int IN3_CH_LSB = 8;
    localparam int IRQ_OVS_LSB = 0;
    localparam int IRQ_NEW_BIT = 4;
    localparam int IRQ_W = 5;

    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
    localparam logic [15:0] K_DEFAULT = 16'h0001;
    localparam logic [15:0] M_UNITY = 16'h2710;

    localparam int CLK_MHZ = 250;
    localparam int STEP_TIME_MS = 500;
    localparam int STEP_CYCLES = STEP_TIME_MS * CLK_MHZ * 1000;
    localparam int MIN_GAP_NS = 100000;
    localparam int MIN_GAP_CYCLES = (MIN_GAP_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        VIEW_DATA = 2'b00,
        VIEW_K = 2'b01,
        VIEW_M = 2'b10,
        VIEW_C = 2'b11
    } pmfs_view_t;

    typedef enum logic [2:0] {
        ST_RDK = 3'b000,
        ST_RDM = 3'b001,
        ST_MUL = 3'b010,
        ST_DIVC = 3'b011,
        ST_DIVD = 3'b100
    } pmfs_state_t;
endpackage : pmfs_pkg

`timescale 1ns/1ps
module pmfs_store #(
    parameter int W = 16,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [W-1:0] rd_data_o
);
    logic [W-1:0] mem [2**AW];
    logic [W-1:0] rd_next;

    always_comb
    begin
        rd_next = mem[rd_addr_i];
    end

    // contents are not reset; the owner keeps per-entry loaded flags
    always_ff @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_addr_i] <= wr_data_i;
        end
        if (reset_i)
        begin
            rd_data_o <= '0;
        end
        else
        begin
            rd_data_o <= rd_next;
        end
    end
endmodule : pmfs_store

// File: pmfs_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - K factor per channel, 1 to 65535
// - meter factor has four implied decimals
// - unloaded meter factor defaults to 10000
// - C factor equals K times M over 10000
// - control word 2 selects viewed factor
// - auto scan steps channel every half second
// - four data-valid bits in input register 3
// - control word 1 bits pick manual channel
// - overspeed bits flag possibly inaccurate data
// - six 16-bit registers, three each way
module pmfs_top
    import pmfs_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES,
    parameter int GAP_CYC = MIN_GAP_CYCLES,
    parameter int CNT_WIDTH = CNT_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [NUM_CH-1:0] pulse_i,
    output logic irq_o
);
    function automatic logic [15:0] sat16(input logic [DIV_W-1:0] v);
        sat16 = (|v[DIV_W-1:16]) ? 16'hffff : v[15:0];
    endfunction : sat16

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    // pulse pins are asynchronous: two flops, then edge detect on the second
    logic [NUM_CH-1:0] p_meta_reg, p_sync_reg, p_prev_reg;
    logic [NUM_CH-1:0] p_edge;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            p_meta_reg <= '0;
            p_sync_reg <= '0;
            p_prev_reg <= '0;
        end
        else
        begin
            p_meta_reg <= pulse_i;
            p_sync_reg <= p_meta_reg;
            p_prev_reg <= p_sync_reg;
        end
    end

    always_comb
    begin
        p_edge = p_sync_reg & ~p_prev_reg;
    end

    // bus slave state
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] out1_reg, out1_next, cw1_reg, cw1_next, cw2_reg, cw2_next;
    logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
    logic irq_reg, irq_next;
    logic wr_hit, ld_k, ld_m, clr_ovs, clr_cnt;
    logic [CH_W-1:0] ld_ch;
    logic [15:0] in1_val, in3_val;
    logic [IRQ_W-1:0] irq_evt;

    // channel and sequencing state
    logic [CH_W-1:0] ch_reg, ch_next;
    logic [31:0] tick_reg, tick_next;
    logic [NUM_CH-1:0] k_set_reg, k_set_next, m_set_reg, m_set_next;
    logic auto_en, step, restart;

    // compute state
    pmfs_state_t st_reg, st_next;
    logic [15:0] k_reg, k_next, m_reg, m_next, disp_reg, disp_next;
    logic [31:0] km_reg, km_next, c_reg, c_next;
    logic [DIV_W-1:0] num_reg, num_next;
    logic [31:0] den_reg, den_next;
    logic [32:0] rem_reg, rem_next, rem_sh;
    logic [5:0] dcnt_reg, dcnt_next;
    logic [CNT_WIDTH-1:0] snap_reg, snap_next, cur_cnt;
    logic [NUM_CH-1:0] valid_reg, valid_next;
    logic div_ge, new_evt;
    logic [DIV_W-1:0] q_next;
    logic [CH_W:0] mem_rd_addr;
    logic [15:0] mem_rd_data;

    logic [NUM_CH-1:0] ovs_evt, ovs_vec;
    logic [NUM_CH*CNT_WIDTH-1:0] cnt_flat;

    always_comb
    begin
        wr_hit = avs_write_i & ~wait_reg;
        cw1_next = cw1_reg;
        out1_next = out1_reg;
        cw2_next = cw2_reg;
        imask_next = imask_reg;
        if (wr_hit && avs_address_i == OFS_OUT1)
        begin
            out1_next = merge16(out1_reg, avs_writedata_i, avs_byteenable_i);
        end
        if (wr_hit && avs_address_i == OFS_OUT2)
        begin
            cw1_next = merge16(cw1_reg, avs_writedata_i, avs_byteenable_i);
        end
        if (wr_hit && avs_address_i == OFS_OUT3)
        begin
            cw2_next = merge16(cw2_reg, avs_writedata_i, avs_byteenable_i);
        end
        if (wr_hit && avs_address_i == OFS_IRQ_MASK && avs_byteenable_i[0])
        begin
            imask_next = avs_writedata_i[IRQ_W-1:0];
        end
        // load and clear bits act only in the write that carries them
        ld_ch = cw1_next[CW1_LOAD_CH_LSB +: CH_W];
        ld_k = wr_hit && avs_address_i == OFS_OUT2 && avs_byteenable_i[0] && avs_writedata_i[CW1_LOAD_K_BIT]
            && out1_reg != 16'h0000;
        // a zero meter factor would divide by zero, so it is refused; K wins if both loads coincide
        ld_m = wr_hit && avs_address_i == OFS_OUT2 && avs_byteenable_i[0] && avs_writedata_i[CW1_LOAD_M_BIT]
            && out1_reg != 16'h0000 && !ld_k;
        clr_ovs = wr_hit && avs_address_i == OFS_OUT2 && avs_byteenable_i[0] && avs_writedata_i[CW1_CLR_OVS_BIT];
        clr_cnt = wr_hit && avs_address_i == OFS_OUT2 && avs_byteenable_i[1] && avs_writedata_i[CW1_CLR_CNT_BIT];
        k_set_next = k_set_reg;
        m_set_next = m_set_reg;
        if (ld_k)
        begin
            k_set_next[ld_ch] = 1'b1;
        end
        if (ld_m)
        begin
            m_set_next[ld_ch] = 1'b1;
        end
    end

    always_comb
    begin
        case (pmfs_view_t'(cw2_reg[CW2_VIEW_LSB +: 2]))
            VIEW_DATA: in1_val = disp_reg;
            VIEW_K: in1_val = k_reg;
            VIEW_M: in1_val = m_reg;
            VIEW_C: in1_val = sat16({16'h0000, c_reg});
            default: in1_val = disp_reg;
        endcase
        in3_val = REG_RST;
        in3_val[IN3_VALID_LSB +: NUM_CH] = valid_reg;
        in3_val[IN3_OVS_LSB +: NUM_CH] = ovs_vec;
        in3_val[IN3_CH_LSB +: CH_W] = ch_reg;
        // answer one cycle after the request rises, data registered for that cycle
        wait_next = ~((avs_read_i | avs_write_i) & wait_reg);
        rdata_next = rdata_reg;
        if (avs_read_i && wait_reg)
        begin
            case (avs_address_i)
                OFS_IN1: rdata_next = {16'h0000, in1_val};
                OFS_IN2: rdata_next = {16'h0000, cur_cnt[15:0]};
                OFS_IN3: rdata_next = {16'h0000, in3_val};
                OFS_OUT1: rdata_next = {16'h0000, out1_reg};
                OFS_OUT2: rdata_next = {16'h0000, cw1_reg};
                OFS_OUT3: rdata_next = {16'h0000, cw2_reg};
                OFS_IRQ_STAT: rdata_next = {27'h0000000, istat_reg};
                OFS_IRQ_MASK: rdata_next = {27'h0000000, imask_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        irq_evt = IRQ_RST;
        irq_evt[IRQ_OVS_LSB +: NUM_CH] = ovs_evt;
        irq_evt[IRQ_NEW_BIT] = new_evt;
        istat_next = istat_reg;
        if (wr_hit && avs_address_i == OFS_IRQ_STAT && avs_byteenable_i[0])
        begin
            istat_next = istat_reg & ~avs_writedata_i[IRQ_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        istat_next = istat_next | irq_evt;
        irq_next = |(istat_next & imask_next);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            out1_reg <= REG_RST;
            cw1_reg <= REG_RST;
            cw2_reg <= REG_RST;
            istat_reg <= IRQ_RST;
            imask_reg <= IRQ_RST;
            irq_reg <= 1'b0;
            k_set_reg <= '0;
            m_set_reg <= '0;
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            out1_reg <= out1_next;
            cw1_reg <= cw1_next;
            cw2_reg <= cw2_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            irq_reg <= irq_next;
            k_set_reg <= k_set_next;
            m_set_reg <= m_set_next;
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign avs_readdata_o = rdata_reg;
    assign irq_o = irq_reg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            logic [CNT_WIDTH-1:0] cnt_reg, cnt_next;
            logic [31:0] gap_reg, gap_next;
            logic ovs_reg, ovs_next, evt;

            always_comb
            begin
                // a pulse edge in the clearing cycle is kept as the first count
                cnt_next = clr_cnt ? '0 : cnt_reg;
                if (p_edge[gi] && cnt_next != {CNT_WIDTH{1'b1}})
                begin
                    cnt_next = cnt_next + 1'b1;
                end
                gap_next = p_edge[gi] ? 32'h00000000 : (gap_reg == 32'(GAP_CYC)) ? gap_reg : gap_reg + 32'h1;
                evt = p_edge[gi] && gap_reg < 32'(GAP_CYC - 1);
                ovs_next = evt | (ovs_reg & ~clr_ovs);
            end

            always_ff @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    cnt_reg <= '0;
                    gap_reg <= 32'(GAP_CYC);
                    ovs_reg <= 1'b0;
                end
                else
                begin
                    cnt_reg <= cnt_next;
                    gap_reg <= gap_next;
                    ovs_reg <= ovs_next;
                end
            end

            assign ovs_evt[gi] = evt;
            assign ovs_vec[gi] = ovs_reg;
            assign cnt_flat[gi*CNT_WIDTH +: CNT_WIDTH] = cnt_reg;
        end
    endgenerate

    always_comb
    begin
        auto_en = cw1_reg[CW1_AUTO_BIT];
        step = 1'b0;
        tick_next = 32'h00000000;
        ch_next = ch_reg;
        if (auto_en)
        begin
            if (tick_reg == 32'(STEP_CYC - 1))
            begin
                step = 1'b1;
            end
            else
            begin
                tick_next = tick_reg + 32'h1;
            end
            ch_next = step ? ch_reg + 1'b1 : ch_reg;
        end
        else
        begin
            // lowest set select bit wins; none set keeps the current channel
            for (int i = NUM_CH - 1; i >= 0; i--)
            begin
                if (cw1_reg[CW1_SEL_LSB + i])
                begin
                    ch_next = CH_W'(i);
                end
            end
        end
        restart = (ch_next != ch_reg) | ld_k | ld_m;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ch_reg <= '0;
            tick_reg <= 32'h00000000;
        end
        else
        begin
            ch_reg <= ch_next;
            tick_reg <= tick_next;
        end
    end

    pmfs_store #(.W(16), .AW(CH_W + 1)) u_store (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .wr_en_i(ld_k | ld_m),
        .wr_addr_i({ld_m, ld_ch}),
        .wr_data_i(out1_reg),
        .rd_addr_i(mem_rd_addr),
        .rd_data_o(mem_rd_data)
    );

    always_comb
    begin
        cur_cnt = cnt_flat[ch_reg*CNT_WIDTH +: CNT_WIDTH];
        st_next = st_reg;
        k_next = k_reg;
        m_next = m_reg;
        km_next = km_reg;
        c_next = c_reg;
        disp_next = disp_reg;
        num_next = num_reg;
        den_next = den_reg;
        rem_next = rem_reg;
        dcnt_next = dcnt_reg;
        snap_next = snap_reg;
        valid_next = valid_reg;
        new_evt = 1'b0;
        mem_rd_addr = {1'b0, ch_reg};
        // one restoring step of the shared serial divider
        rem_sh = {rem_reg[31:0], num_reg[DIV_W-1]};
        div_ge = rem_sh >= {1'b0, den_reg};
        q_next = {num_reg[DIV_W-2:0], div_ge};
        case (st_reg)
            ST_RDK:
            begin
                st_next = ST_RDM;
            end
            ST_RDM:
            begin
                mem_rd_addr = {1'b1, ch_reg};
                k_next = k_set_reg[ch_reg] ? mem_rd_data : K_DEFAULT;
                st_next = ST_MUL;
            end
            ST_MUL:
            begin
                m_next = m_set_reg[ch_reg] ? mem_rd_data : M_UNITY;
                km_next = 32'(k_reg) * 32'(m_next);
                num_next = {16'h0000, km_next};
                den_next = {16'h0000, M_UNITY};
                rem_next = '0;
                dcnt_next = '0;
                st_next = ST_DIVC;
            end
            ST_DIVC, ST_DIVD:
            begin
                rem_next = div_ge ? rem_sh - {1'b0, den_reg} : rem_sh;
                num_next = q_next;
                dcnt_next = dcnt_reg + 6'h01;
                if (dcnt_reg == 6'(DIV_STEPS - 1))
                begin
                    rem_next = '0;
                    dcnt_next = '0;
                    if (st_reg == ST_DIVC)
                    begin
                        c_next = q_next[31:0];
                        // full precision: pulses*10000/(K*M) keeps fractional C exact
                        snap_next = cur_cnt;
                        num_next = DIV_W'(cur_cnt) * DIV_W'(M_UNITY);
                        den_next = km_reg;
                        st_next = ST_DIVD;
                    end
                    else
                    begin
                        disp_next = sat16(q_next);
                        valid_next = NUM_CH'(1) << ch_reg;
                        new_evt = 1'b1;
                        st_next = ST_RDK;
                    end
                end
            end
            default:
            begin
                st_next = ST_RDK;
            end
        endcase
        if (restart)
        begin
            st_next = ST_RDK;
            valid_next = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            st_reg <= ST_RDK;
            k_reg <= K_DEFAULT;
            m_reg <= M_UNITY;
            km_reg <= 32'h00000000;
            c_reg <= 32'h00000000;
            disp_reg <= REG_RST;
            num_reg <= '0;
            den_reg <= 32'h00000000;
            rem_reg <= '0;
            dcnt_reg <= 6'h00;
            snap_reg <= '0;
            valid_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            k_reg <= k_next;
            m_reg <= m_next;
            km_reg <= km_next;
            c_reg <= c_next;
            disp_reg <= disp_next;
            num_reg <= num_next;
            den_reg <= den_next;
            rem_reg <= rem_next;
            dcnt_reg <= dcnt_next;
            snap_reg <= snap_next;
            valid_reg <= valid_next;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    chk_k_nonzero: assert property (st_reg == ST_MUL |-> k_reg != 16'h0000)
        else $error("zero K factor used");
    chk_m_default: assert property (st_reg == ST_MUL && !m_set_reg[ch_reg] |=> m_reg == M_UNITY)
        else $error("meter factor not unity when unloaded");
    chk_c_value: assert property (st_reg == ST_DIVC && dcnt_reg == 6'(DIV_STEPS - 1)
        |=> c_reg == km_reg / {16'h0000, M_UNITY})
        else $error("C factor wrong");
    chk_disp_value: assert property (st_reg == ST_DIVD && dcnt_reg == 6'(DIV_STEPS - 1)
        |=> disp_reg == sat16((DIV_W'(snap_reg) * DIV_W'(M_UNITY)) / DIV_W'(km_reg)))
        else $error("display value wrong");
    chk_view_k: assert property (avs_read_i && wait_reg && avs_address_i == OFS_IN1
        && cw2_reg[1:0] == VIEW_K |=> avs_readdata_o == {16'h0000, $past(k_reg)})
        else $error("K view not returned");
    chk_auto_step: assert property (auto_en && tick_reg == 32'(STEP_CYC - 1)
        |=> ch_reg == CH_W'($past(ch_reg) + 1'b1))
        else $error("auto scan did not step");
    chk_auto_hold: assert property (auto_en && tick_reg != 32'(STEP_CYC - 1) |=> $stable(ch_reg))
        else $error("auto scan stepped early");
    chk_valid_chan: assert property (valid_reg != '0 |-> valid_reg == NUM_CH'(1) << ch_reg)
        else $error("valid bit not for presented channel");
    chk_manual_sel: assert property (!auto_en && cw1_reg[CW1_SEL_LSB] |=> ch_reg == '0)
        else $error("manual select ignored");
    chk_ovs_flag: assert property (|ovs_evt |=> (ovs_vec & $past(ovs_evt)) == $past(ovs_evt))
        else $error("overspeed bit not set");
    chk_cw2_write: assert property (wr_hit && avs_address_i == OFS_OUT3 && avs_byteenable_i[1:0] == 2'b11
        |=> cw2_reg == $past(avs_writedata_i[15:0]))
        else $error("control word 2 write lost");

    cov_auto_step: cover property (auto_en && step);
    cov_valid_set: cover property ($rose(|valid_reg));
    cov_overspeed: cover property (|ovs_evt);
    cov_irq: cover property ($rose(irq_o));
endmodule : pmfs_top

// File: pmfs_top_dummy_guard.sv
`timescale 1ns/1ps

// File: pmfs_pulse_gen.sv
`timescale 1ns/1ps
module pmfs_pulse_gen
    import pmfs_pkg::*;
(
    input wire logic clk_i,
    output logic [NUM_CH-1:0] pulse_o
);
    // field sensor lines rest low between pulses; high for two cycles so the sync flops see it
    initial pulse_o = '0;
    task automatic burst(input int ch, input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            pulse_o[ch] <= 1'b1;
            repeat (2) @(posedge clk_i);
            pulse_o[ch] <= 1'b0;
            repeat (gap - 2) @(posedge clk_i);
        end
    endtask : burst
endmodule : pmfs_pulse_gen

// File: testbench.sv
`timescale 1ns/1ps
module testbench
    import pmfs_pkg::*;
;
    localparam int STEP = 300;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] q;
    wire logic [31:0] rdo;
    wire logic wreq;
    wire logic irq;
    wire logic [NUM_CH-1:0] pulse;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int cur;
    int nxt;

    pmfs_top #(.STEP_CYC(STEP), .GAP_CYC(20), .CNT_WIDTH(CNT_W)) dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .avs_address_i(addr),
        .avs_read_i(rd),
        .avs_write_i(wr),
        .avs_writedata_i(wdata),
        .avs_byteenable_i(4'h3),
        .avs_readdata_o(rdo),
        .avs_waitrequest_o(wreq),
        .pulse_i(pulse),
        .irq_o(irq)
    );
    pmfs_pulse_gen pg (.clk_i(clk_i), .pulse_o(pulse));

    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // request held until waitrequest is sampled low; a dead slave is caught by the cycle ceiling
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wreq !== 1'b0);
        chk("wait cycles", 32'h2, 32'(n));
        q = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask : rd_chk

    task automatic view(input logic [31:0] v, input logic [31:0] e, input string nm);
        xfer(1'b1, OFS_OUT3, v);
        rd_chk(nm, OFS_IN1, e);
    endtask : view

    task automatic load(input int ch, input logic [15:0] k, input logic [15:0] m);
        xfer(1'b1, OFS_OUT1, {16'h0, k});
        xfer(1'b1, OFS_OUT2, (32'h1 << CW1_LOAD_K_BIT) | (32'(ch) << CW1_LOAD_CH_LSB));
        xfer(1'b1, OFS_OUT1, {16'h0, m});
        xfer(1'b1, OFS_OUT2, (32'h1 << CW1_LOAD_M_BIT) | (32'(ch) << CW1_LOAD_CH_LSB));
    endtask : load

    task automatic poll_ch(output int c);
        int n;
        int c0;
        xfer(1'b0, OFS_IN3, 32'h0);
        c0 = q[9:8];
        c = c0;
        n = 0;
        while (c == c0 && n < 200)
        begin
            xfer(1'b0, OFS_IN3, 32'h0);
            c = q[9:8];
            n++;
        end
    endtask : poll_ch

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        chk("reset waitrequest", 32'h1, {31'h0, wreq});
        chk("reset irq", 32'h0, {31'h0, irq});
        chk("reset readdata", 32'h0, rdo);
        view(32'h1, 32'h0001, "default k");
        view(32'h2, 32'h2710, "default m");
        load(0, 16'h0003, 16'h3106);
        load(1, 16'h0001, 16'h1388);
        fork
            pg.burst(0, 40, 30);
            pg.burst(1, 7, 30);
        join
        xfer(1'b1, OFS_OUT2, 32'h0001);
        repeat (250) @(posedge clk_i);
        rd_chk("in3 ch1", OFS_IN3, 32'h0001);
        rd_chk("count ch1", OFS_IN2, 32'h0028);
        view(32'h0, 32'h000a, "display ch1");
        view(32'h1, 32'h0003, "k ch1");
        view(32'h2, 32'h3106, "m ch1");
        view(32'h3, 32'h0003, "c ch1");
        xfer(1'b1, OFS_OUT2, 32'h0002);
        rd_chk("valid after switch", OFS_IN3, 32'h0100);
        repeat (250) @(posedge clk_i);
        rd_chk("in3 ch2", OFS_IN3, 32'h0102);
        view(32'h0, 32'h000e, "display ch2");
        xfer(1'b1, OFS_OUT2, 32'h000c);
        repeat (250) @(posedge clk_i);
        rd_chk("in3 ch3", OFS_IN3, 32'h0204);
        xfer(1'b1, OFS_IRQ_MASK, 32'h0008);
        pg.burst(3, 2, 5);
        repeat (10) @(posedge clk_i);
        rd_chk("in3 overspeed", OFS_IN3, 32'h0284);
        chk("irq raised", 32'h1, {31'h0, irq});
        xfer(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq status", 32'h8, q & 32'h0f);
        chk("new data flag", 32'h1, {31'h0, q[IRQ_NEW_BIT]});
        xfer(1'b1, OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, OFS_IRQ_STAT, 32'h001f);
        xfer(1'b1, OFS_IRQ_MASK, 32'h0008);
        repeat (3) @(posedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq});
        xfer(1'b1, OFS_OUT2, 32'h0080);
        rd_chk("overspeed cleared", OFS_IN3, 32'h0204);
        rd_chk("unmapped", 6'h20, 32'h0);
        // a zero K would later divide by zero, so the load must be dropped
        xfer(1'b1, OFS_OUT1, 32'h0);
        xfer(1'b1, OFS_OUT2, 32'h2020);
        view(32'h1, 32'h0001, "zero k refused");
        xfer(1'b1, OFS_OUT2, 32'h0101);
        rd_chk("count cleared", OFS_IN2, 32'h0);
        xfer(1'b1, OFS_OUT2, 32'h0010);
        poll_ch(cur);
        for (int i = 0; i < 4; i++)
        begin
            repeat (STEP - 30) @(posedge clk_i);
            xfer(1'b0, OFS_IN3, 32'h0);
            chk("auto hold", 32'(cur), 32'(q[9:8]));
            poll_ch(nxt);
            chk("auto step", 32'((cur + 1) % 4), 32'(nxt));
            cur = nxt;
        end
        tally_and_finish();
    end
endmodule : testbench
